// *** axis_stop_brake_sequencer.sv ***
// Switch-off and holding brake sequencer for one servo axis
`timescale 1ns/1ps
module axis_stop_brake_sequencer #(
  parameter int unsigned StandstillTimeout =
    axis_stop_pkg::StandstillTmoCycles
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // Settings
  input  wire logic [1:0]                  disableModeSelect,
  input  wire logic                        brakeImmediateSelect,
  input  wire logic                        undervoltageModeSelect,
  input  wire logic                        brakeFitted,
  input  wire logic [axis_stop_pkg::VelWidth-1:0] standstillVelocityThreshold,
  // Commands and inputs
  input  wire logic                        enableRequest,
  input  wire logic                        axisDisableCommand,
  input  wire logic                        hardwareEnable,
  input  wire logic                        safeTorqueOffActive,
  input  wire logic                        stopInput,
  input  wire logic                        faultEvent,
  input  wire logic [1:0]                  faultClass,
  input  wire logic                        faultClear,
  input  wire logic                        busUndervoltage,
  input  wire logic [axis_stop_pkg::VelWidth-1:0] motorSpeedAbs,
  // Status and actuators
  output logic                             axisActive,
  output logic                             powerStageEnable,
  output logic                             rampDownRequest,
  output logic                             dynamicBrakeRequest,
  output logic                             brakeEngage,
  output logic                             faultRelayOutput,
  output logic                             readyToOperateRelay,
  output logic                             undervoltageFault,
  output logic                             undervoltageWarning,
  output logic                             faultActive,
  output axis_stop_pkg::axis_state_t       axisState
);
  typedef struct packed {
    axis_stop_pkg::axis_state_t fsm;
    logic                       pwr;
    logic                       ramp;
    logic                       dyn;
    logic                       brake;
    logic                       fault;
    logic                       uvFault;
    logic                       uvWarn;
    logic                       active;
    logic                       ready_to_operate_relay;
  } seq_state_t;

  seq_state_t st_q;
  seq_state_t st_d;

  logic timeoutHit;
  logic atStandstill;
  logic timerRun;
  logic uvFaultSet;
  logic anyFault;
  logic hardStop;

  assign atStandstill = motorSpeedAbs <= standstillVelocityThreshold;
  assign timerRun = (st_q.fsm == axis_stop_pkg::StStopping) ||
                    (st_q.fsm == axis_stop_pkg::StDynBrake) ||
                    (st_q.fsm == axis_stop_pkg::StAwaitStill);

  standstill_timer #(
    .Width (axis_stop_pkg::TmoWidth)
  ) u_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (timerRun),
    .limit   (axis_stop_pkg::TmoWidth'(StandstillTimeout)),
    .expired (timeoutHit)
  );

  always_comb
  begin
    uvFaultSet = 1'b0;
    if (busUndervoltage)
    begin
      if (!undervoltageModeSelect)
        uvFaultSet = 1'b1;
      else if (st_q.fsm != axis_stop_pkg::StBraked || enableRequest)
        uvFaultSet = 1'b1;
    end
  end

  assign anyFault = faultEvent || uvFaultSet;
  // Hardware disable, torque off and class-0 faults cut power without ramp
  assign hardStop = !hardwareEnable || safeTorqueOffActive ||
                    uvFaultSet ||
                    (faultEvent && faultClass == axis_stop_pkg::FaultClassOff);

  always_comb
  begin
    st_d = st_q;
    // Set wins over clear for the sticky fault flags
    if (faultClear)
    begin
      st_d.fault   = 1'b0;
      st_d.uvFault = 1'b0;
    end
    if (anyFault)
      st_d.fault = 1'b1;
    if (uvFaultSet)
      st_d.uvFault = 1'b1;
    st_d.uvWarn = busUndervoltage && undervoltageModeSelect &&
                  !uvFaultSet;
    case (st_q.fsm)
      axis_stop_pkg::StBraked:
      begin
        // Re-arms the brake if it was masked while parked
        st_d.brake = 1'b1;
        if (enableRequest && hardwareEnable && !safeTorqueOffActive &&
            !st_q.fault && !anyFault && !stopInput && !axisDisableCommand)
        begin
          st_d.fsm   = axis_stop_pkg::StEnabled;
          st_d.pwr   = 1'b1;
          st_d.brake = 1'b0;
        end
      end
      axis_stop_pkg::StEnabled, axis_stop_pkg::StStopping,
      axis_stop_pkg::StDynBrake:
      begin
        // Harshest pending stop takes over
        if (hardStop)
        begin
          st_d.fsm  = axis_stop_pkg::StAwaitStill;
          st_d.pwr  = 1'b0;
          st_d.ramp = 1'b0;
          st_d.dyn  = 1'b0;
          if (brakeImmediateSelect && (faultEvent || uvFaultSet ||
              !hardwareEnable || safeTorqueOffActive))
            st_d.brake = 1'b1;
        end
        else if (faultEvent && faultClass == axis_stop_pkg::FaultClassDynamic)
        begin
          st_d.fsm   = axis_stop_pkg::StDynBrake;
          st_d.pwr   = 1'b0;
          st_d.ramp  = 1'b0;
          st_d.dyn   = 1'b1;
          st_d.brake = brakeImmediateSelect;
        end
        else if (st_q.fsm == axis_stop_pkg::StEnabled &&
                 axisDisableCommand &&
                 disableModeSelect != axis_stop_pkg::DisModeControlled)
        begin
          st_d.fsm = axis_stop_pkg::StAwaitStill;
          st_d.pwr = 1'b0;
        end
        else if (st_q.fsm == axis_stop_pkg::StEnabled &&
                 (stopInput || faultEvent || axisDisableCommand))
        begin
          st_d.fsm  = axis_stop_pkg::StStopping;
          st_d.ramp = 1'b1;
          if (faultEvent && brakeImmediateSelect)
            st_d.brake = 1'b1;
        end
        else if (st_q.fsm != axis_stop_pkg::StEnabled &&
                 (atStandstill || timeoutHit))
        begin
          st_d.fsm   = axis_stop_pkg::StBraked;
          st_d.pwr   = 1'b0;
          st_d.ramp  = 1'b0;
          st_d.dyn   = 1'b0;
          st_d.brake = 1'b1;
        end
      end
      axis_stop_pkg::StAwaitStill:
      begin
        st_d.pwr = 1'b0;
        if (atStandstill || timeoutHit)
        begin
          st_d.fsm   = axis_stop_pkg::StBraked;
          st_d.brake = 1'b1;
        end
      end
      default:
      begin
        st_d.fsm   = axis_stop_pkg::StBraked;
        st_d.pwr   = 1'b0;
        st_d.brake = 1'b1;
      end
    endcase
    if (!brakeFitted)
      st_d.brake = 1'b0;
    st_d.active = st_d.fsm == axis_stop_pkg::StEnabled;
    st_d.ready_to_operate_relay    = !st_d.fault;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q       <= '0;
      st_q.fsm   <= axis_stop_pkg::StBraked;
      st_q.brake <= 1'b1;
      st_q.ready_to_operate_relay   <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign axisActive          = st_q.active;
  assign powerStageEnable    = st_q.pwr;
  assign rampDownRequest     = st_q.ramp;
  assign dynamicBrakeRequest = st_q.dyn;
  assign brakeEngage         = st_q.brake;
  assign faultRelayOutput    = st_q.fault;
  assign readyToOperateRelay = st_q.ready_to_operate_relay;
  assign undervoltageFault   = st_q.uvFault;
  assign undervoltageWarning = st_q.uvWarn;
  assign faultActive         = st_q.fault;
  assign axisState           = st_q.fsm;

  property p_active_drop_brake;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(axisActive) && brakeFitted && brakeImmediateSelect &&
      safeTorqueOffActive |-> brakeEngage;
  endproperty
  a_active_drop_brake: assert property (p_active_drop_brake)
    else $error("brake not engaged on torque off");

  property p_standstill_brake;
    @(posedge sys_clk) disable iff (!resetn)
      st_q.fsm == axis_stop_pkg::StAwaitStill && atStandstill &&
      brakeFitted |=> brakeEngage && !axisActive;
  endproperty
  a_standstill_brake: assert property (p_standstill_brake)
    else $error("brake not engaged at standstill");

  property p_hw_enable_off;
    @(posedge sys_clk) disable iff (!resetn)
      axisActive && !hardwareEnable |=> !powerStageEnable && !rampDownRequest;
  endproperty
  a_hw_enable_off: assert property (p_hw_enable_off)
    else $error("power stage not cut on hardware disable");

  property p_sto_off;
    @(posedge sys_clk) disable iff (!resetn)
      safeTorqueOffActive |=> !powerStageEnable;
  endproperty
  a_sto_off: assert property (p_sto_off)
    else $error("power stage on during torque off");

  property p_uv_mode0;
    @(posedge sys_clk) disable iff (!resetn)
      busUndervoltage && !undervoltageModeSelect |=> undervoltageFault;
  endproperty
  a_uv_mode0: assert property (p_uv_mode0)
    else $error("undervoltage fault missing in mode 0");

  property p_uv_warn;
    @(posedge sys_clk) disable iff (!resetn)
      busUndervoltage && undervoltageModeSelect && !enableRequest &&
      st_q.fsm == axis_stop_pkg::StBraked
      |=> undervoltageWarning && !$rose(undervoltageFault);
  endproperty
  a_uv_warn: assert property (p_uv_warn)
    else $error("undervoltage warning wrong");

  property p_uv_enabled;
    @(posedge sys_clk) disable iff (!resetn)
      busUndervoltage && axisActive |=> undervoltageFault ##0 !axisActive;
  endproperty
  a_uv_enabled: assert property (p_uv_enabled)
    else $error("undervoltage while enabled not faulted");

  property p_dis_ramp;
    @(posedge sys_clk) disable iff (!resetn)
      axisActive && axisDisableCommand && hardwareEnable &&
      !safeTorqueOffActive && !faultEvent && !busUndervoltage &&
      disableModeSelect == axis_stop_pkg::DisModeControlled
      |=> rampDownRequest && powerStageEnable;
  endproperty
  a_dis_ramp: assert property (p_dis_ramp)
    else $error("controlled disable did not ramp");

  property p_fault_relay;
    @(posedge sys_clk) disable iff (!resetn)
      faultEvent |=> faultRelayOutput && !readyToOperateRelay;
  endproperty
  a_fault_relay: assert property (p_fault_relay)
    else $error("fault relay not driven on fault");
endmodule // axis_stop_brake_sequencer

// *** axis_stop_pkg.sv ***
// Constants and types shared by the axis stop and brake sequencer
// Summary of operation
// - Holding brake engages on reaching braked state, not on losing axis active.
// - In any stop, brake engages at standstill speed or timeout, first wins.
// - Immediate brake select: brake at once on fault or hardware disable.
// - Undervoltage mode 0: any bus undervoltage raises undervoltage fault.
// - Mode 1 (default): undervoltage while braked, no enable requested, raises only a warning.
// - Mode 1: undervoltage while enabled, or enable requested, raises fault.
// - Hardware enable removal switches power stage off at once, no ramp.
// - Safe torque off cuts power stage at once; brake on standstill/timeout.
// - Immediate brake select set: brake at once after safe torque off too.
// - Disable command, mode 0: disable at once, brake at standstill/timeout.
// - Disable command, mode 2: controlled ramp, disable, then brake.
// - Disable command behaves the same whatever its source.
// - Stop input: controlled ramp to rest, disable, engage brake if fitted.
// - Any fault opens the fault relay to drop the mains contactor.
// - Fault classes: power stage off, dynamic braking, controlled stop.
package axis_stop_pkg;
  localparam int unsigned ClkHz           = 20_000_000;
  localparam int unsigned StandstillTmoMs = 100;
  localparam int unsigned StandstillTmoCycles =
    StandstillTmoMs * (ClkHz / 1000);
  localparam int unsigned TmoWidth        = 24;
  localparam int unsigned VelWidth        = 16;
  localparam logic [1:0]  DisModeImmediate  = 2'h0;
  localparam logic [1:0]  DisModeControlled = 2'h2;
  localparam logic [1:0]  FaultClassOff     = 2'h0;
  localparam logic [1:0]  FaultClassDynamic = 2'h1;
  localparam logic [1:0]  FaultClassRamp    = 2'h2;
  localparam logic        UvModeDefault     = 1'b1;

  typedef enum logic [2:0] {
    StBraked,
    StEnabled,
    StStopping,
    StDynBrake,
    StAwaitStill
  } axis_state_t;
endpackage

// *** standstill_timer.sv ***
// Standstill watchdog counter for one stop procedure
`timescale 1ns/1ps
module standstill_timer #(
  parameter int unsigned Width = 24
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             run,
  input  wire logic [Width-1:0] limit,
  // Result
  output logic                  expired
);
  typedef struct packed {
    logic [Width-1:0] cnt;
    logic             exp;
  } tmr_state_t;

  tmr_state_t st_q;
  tmr_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (!run)
    begin
      st_d.cnt = '0;
      st_d.exp = 1'b0;
    end
    else if (st_q.cnt >= limit)
      st_d.exp = 1'b1;
    else
      st_d.cnt = st_q.cnt + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign expired = st_q.exp;
endmodule // standstill_timer

// *** motor_speed_model.sv ***
// Behavioural motor and holding brake seen by the axis sequencer
`timescale 1ns/1ps
module motor_speed_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Drive side
  input  wire logic        powerStageEnable,
  input  wire logic        rampDownRequest,
  input  wire logic        dynamicBrakeRequest,
  input  wire logic        brakeEngage,
  input  wire logic        stall,
  // Feedback
  output logic [15:0]      motorSpeedAbs
);
  // Stall freezes the speed so only the timeout can end a stop
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      motorSpeedAbs <= 16'h0;
    else if (stall)
      motorSpeedAbs <= motorSpeedAbs;
    else if (brakeEngage && !powerStageEnable)
      motorSpeedAbs <= 16'h0;
    else if (rampDownRequest || dynamicBrakeRequest)
      motorSpeedAbs <= (motorSpeedAbs > 16'h64) ?
                       motorSpeedAbs - 16'h64 : 16'h0;
    else if (powerStageEnable)
      motorSpeedAbs <= 16'h3e8;
    else
      motorSpeedAbs <= (motorSpeedAbs > 16'h4) ? motorSpeedAbs - 16'h4 : 16'h0;
  end
endmodule // motor_speed_model

// *** testbench.sv ***
// Self-checking bench for the axis stop and brake sequencer
`timescale 1ns/1ps
module testbench;
  localparam int unsigned Tmo = 20;
  typedef struct packed {
    logic [2:0] cause;
    logic [1:0] mode;
    logic [1:0] cls;
    logic       imm;
    logic [2:0] st;
    logic [1:0] pse;
    logic       brk;
    logic       flt;
  } row_t;
  logic        sysClk = 1'b0;
  logic        resetn = 1'b0;
  logic [1:0]  disMode = 2'h0;
  logic        brkImm = 1'b0;
  logic        uvMode = 1'b1;
  logic        fitted = 1'b1;
  logic        enReq = 1'b0;
  logic        disCmd = 1'b0;
  logic        hwEn = 1'b1;
  logic        sto = 1'b0;
  logic        stopIn = 1'b0;
  logic        fltEv = 1'b0;
  logic [1:0]  fltCls = 2'h0;
  logic        fltClr = 1'b0;
  logic        busUv = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] speed;
  logic [15:0] zeroV = 16'h000a;
  logic        fltAct;
  logic        active, pse, ramp, dyn, brk, relay, ready_to_operate_relay, uvFlt, uvWarn;
  axis_stop_pkg::axis_state_t state;
  int          bad_count = 0;
  int          n_checks = 0;
  int          i;
  int          k;
  // Cause 0 hw enable, 1 torque off, 2 disable, 3 stop input, 4 fault
  row_t rows [13] = '{
    '{3'h0,2'h0,2'h0,1'h0,3'h4,2'h0,1'h0,1'h0},
    '{3'h0,2'h0,2'h0,1'h1,3'h4,2'h0,1'h1,1'h0},
    '{3'h1,2'h0,2'h0,1'h0,3'h4,2'h0,1'h0,1'h0},
    '{3'h1,2'h0,2'h0,1'h1,3'h4,2'h0,1'h1,1'h0},
    '{3'h2,2'h0,2'h0,1'h0,3'h4,2'h0,1'h0,1'h0},
    '{3'h2,2'h3,2'h0,1'h0,3'h4,2'h0,1'h0,1'h0},
    '{3'h2,2'h2,2'h0,1'h0,3'h2,2'h1,1'h0,1'h0},
    '{3'h3,2'h0,2'h0,1'h0,3'h2,2'h1,1'h0,1'h0},
    '{3'h4,2'h0,2'h0,1'h0,3'h4,2'h0,1'h0,1'h1},
    '{3'h4,2'h0,2'h0,1'h1,3'h4,2'h0,1'h1,1'h1},
    '{3'h4,2'h0,2'h1,1'h0,3'h3,2'h2,1'h0,1'h1},
    '{3'h4,2'h0,2'h2,1'h0,3'h2,2'h1,1'h0,1'h1},
    '{3'h4,2'h0,2'h3,1'h1,3'h2,2'h1,1'h1,1'h1}};

  initial
  begin
    forever #25 sysClk = ~sysClk;
  end

  axis_stop_brake_sequencer #(.StandstillTimeout(Tmo))
    u_axis_stop_brake_sequencer (
    .sys_clk(sysClk), .resetn(resetn), .disableModeSelect(disMode),
    .brakeImmediateSelect(brkImm), .undervoltageModeSelect(uvMode),
    .brakeFitted(fitted), .standstillVelocityThreshold(zeroV),
    .enableRequest(enReq), .axisDisableCommand(disCmd), .hardwareEnable(hwEn),
    .safeTorqueOffActive(sto), .stopInput(stopIn), .faultEvent(fltEv),
    .faultClass(fltCls), .faultClear(fltClr), .busUndervoltage(busUv),
    .motorSpeedAbs(speed), .axisActive(active), .powerStageEnable(pse),
    .rampDownRequest(ramp), .dynamicBrakeRequest(dyn), .brakeEngage(brk),
    .faultRelayOutput(relay), .readyToOperateRelay(ready_to_operate_relay),
    .undervoltageFault(uvFlt), .undervoltageWarning(uvWarn),
    .faultActive(fltAct), .axisState(state));

  motor_speed_model u_motor_speed_model (
    .sys_clk(sysClk), .resetn(resetn), .powerStageEnable(pse),
    .rampDownRequest(ramp), .dynamicBrakeRequest(dyn), .brakeEngage(brk),
    .stall(stall), .motorSpeedAbs(speed));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sysClk);
  endtask

  task automatic waitBraked(output int c);
    c = 0;
    while (state !== axis_stop_pkg::StBraked && c < 400)
    begin
      @(negedge sysClk);
      c++;
    end
    if (c >= 400)
    begin
      chk("wait", 8'h1, 8'h0);
      tally_and_finish();
    end
  endtask

  task automatic go;
    enReq = 1'b1;
    cyc(2);
    chk("active", 8'h1, {7'h0, active});
  endtask

  // Clears sticky faults and lets the axis settle back to braked
  task automatic quiet;
    int c;
    {enReq, disCmd, sto, stopIn, busUv, stall} = 6'h0;
    hwEn = 1'b1;
    fltClr = 1'b1;
    cyc(1);
    fltClr = 1'b0;
    waitBraked(c);
    cyc(1);
  endtask

  initial
  begin
    cyc(6);
    resetn = 1'b1;
    cyc(1);
    for (i = 0; i < 13; i++)
    begin
      disMode = rows[i].mode;
      brkImm = rows[i].imm;
      fltCls = rows[i].cls;
      go();
      case (rows[i].cause)
        3'h0: hwEn = 1'b0;
        3'h1: sto = 1'b1;
        3'h2: disCmd = 1'b1;
        3'h3: stopIn = 1'b1;
        default: fltEv = 1'b1;
      endcase
      cyc(1);
      fltEv = 1'b0;
      chk("state", {5'h0, rows[i].st}, {5'h0, state});
      if (rows[i].pse != 2'h2)
        chk("power", {7'h0, rows[i].pse[0]}, {7'h0, pse});
      chk("ramp", {7'h0, rows[i].st == 3'h2}, {7'h0, ramp});
      chk("dyn", {7'h0, rows[i].st == 3'h3}, {7'h0, dyn});
      chk("brake", {7'h0, rows[i].brk}, {7'h0, brk});
      chk("relay", {7'h0, rows[i].flt}, {7'h0, relay});
      chk("rto", {7'h0, ~rows[i].flt}, {7'h0, ready_to_operate_relay});
      chk("factive", {7'h0, rows[i].flt}, {7'h0, fltAct});
      chk("active", 8'h0, {7'h0, active});
      waitBraked(k);
      chk("brake", 8'h1, {7'h0, brk});
      chk("power", 8'h0, {7'h0, pse});
      quiet();
    end
    go();
    stall = 1'b1;
    stopIn = 1'b1;
    waitBraked(k);
    chk("timeout", 8'h1, {7'h0, k >= Tmo + 1 && k <= Tmo + 4});
    quiet();
    // Threshold at full speed: the await state must end on standstill
    go();
    zeroV = 16'h03e8;
    hwEn = 1'b0;
    cyc(2);
    chk("still", 8'h0, {5'h0, state});
    chk("sbrake", 8'h1, {7'h0, brk});
    zeroV = 16'h000a;
    quiet();
    fitted = 1'b0;
    go();
    stopIn = 1'b1;
    waitBraked(k);
    chk("unfitted", 8'h0, {7'h0, brk});
    fitted = 1'b1;
    quiet();
    busUv = 1'b1;
    cyc(2);
    chk("uvwarn", 8'h1, {7'h0, uvWarn});
    chk("uvflt", 8'h0, {7'h0, uvFlt});
    enReq = 1'b1;
    cyc(2);
    chk("uvflt", 8'h1, {7'h0, uvFlt});
    chk("active", 8'h0, {7'h0, active});
    quiet();
    uvMode = 1'b0;
    busUv = 1'b1;
    cyc(2);
    chk("uvflt", 8'h1, {7'h0, uvFlt});
    quiet();
    uvMode = 1'b1;
    go();
    busUv = 1'b1;
    cyc(2);
    chk("uvflt", 8'h1, {7'h0, uvFlt});
    chk("power", 8'h0, {7'h0, pse});
    quiet();
    go();
    resetn = 1'b0;
    #1;
    chk("rbrake", 8'h1, {7'h0, brk});
    chk("rrto", 8'h1, {7'h0, ready_to_operate_relay});
    chk("rpower", 8'h0, {7'h0, pse});
    chk("rstate", 8'h0, {5'h0, state});
    tally_and_finish();
  end
endmodule // testbench
